// ===== gpm_pkg.sv
package gpm_pkg;

  // ----------------------------------------------------------------
  // Configuration bit positions
  // ----------------------------------------------------------------
  localparam int GC_EXT_IO      = 0;
  localparam int GC_REQ_A       = 8;
  localparam int GC_CLK_IRQ     = 14;
  localparam int GC_MGMT_ALERT  = 15;
  localparam int GC_SERIAL_IRQ  = 16;
  localparam int GC_SUSPEND     = 17;
  localparam int GC_CPU_STOP    = 18;
  localparam int GC_BUS_STOP    = 19;
  localparam int GC_CACHE_SLEEP = 20;
  localparam int GC_SUSPEND_STATUS_ONE_N   = 21;
  localparam int GC_SUSPEND_STATUS_TWO_N   = 22;
  localparam int GC_THERMAL     = 23;
  localparam int GC_BATTERY     = 24;
  localparam int GC_LID         = 25;
  localparam int GC_RING        = 27;
  localparam int GC_XBUS_XCVR   = 28;
  localparam int GC_CLK_SELECT  = 29;
  localparam int GC_CLK_ALE     = 30;
  localparam int GC_KBD_SELECT  = 31;
  localparam int XB_EXT_INTC    = 8;

  // ----------------------------------------------------------------
  // Register offsets from the power management base
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_LEVEL_OFS  = 8'h30;
  localparam logic [7:0] OUT_LEVEL_OFS  = 8'h34;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int GPI_W = 22;
  localparam int GPO_W = 31;
  // Pins whose default owner is an alternate function start with their bit
  // set; bit 0 starts set so that inputs 0 and outputs 1 to 7 start general.
  localparam logic [31:0] GEN_CONFIG_RST = 32'hFF_FE_80_01;
  localparam logic [15:0] XBUS_CFG_RST   = 16'h0000;
  localparam logic [30:0] GPO_RST        = 31'h0000_0000;

endpackage

// ===== gpm_sel_if.sv
interface gpm_sel_if;
  import gpm_pkg::*;
  logic [GPI_W-1:0] alt_in;
  logic [GPO_W-1:0] alt_out;

  modport ctrl (output alt_in, output alt_out);
  modport mux  (input alt_in, input alt_out);
endinterface

// ===== gpm_select.sv
module gpm_select
  import gpm_pkg::*;
(
  input wire logic [31:0] gen_cfg,
  input wire logic [15:0] xbus_cfg,
  gpm_sel_if.ctrl         sel
);

  logic ext_intc;
  assign ext_intc = xbus_cfg[XB_EXT_INTC];

  // ----------------------------------------------------------------
  // Input ownership: 1 means the alternate function owns the pin
  // ----------------------------------------------------------------
  always_comb begin
    sel.alt_in = '0;
    sel.alt_in[0]  = ~gen_cfg[GC_EXT_IO];
    for (int i = 0; i < 3; i++) begin
      sel.alt_in[2+i] = gen_cfg[GC_REQ_A+i];
    end
    sel.alt_in[5]  = ext_intc;
    sel.alt_in[6]  = gen_cfg[GC_CLK_IRQ] | ext_intc;
    sel.alt_in[7]  = gen_cfg[GC_SERIAL_IRQ];
    sel.alt_in[8]  = gen_cfg[GC_THERMAL];
    sel.alt_in[9]  = gen_cfg[GC_BATTERY];
    sel.alt_in[10] = gen_cfg[GC_LID];
    sel.alt_in[11] = gen_cfg[GC_MGMT_ALERT];
    sel.alt_in[12] = gen_cfg[GC_RING];
  end

  // ----------------------------------------------------------------
  // Output ownership
  // ----------------------------------------------------------------
  always_comb begin
    sel.alt_out = '0;
    for (int i = 1; i <= 7; i++) begin
      sel.alt_out[i] = ~gen_cfg[GC_EXT_IO];
    end
    for (int i = 0; i < 3; i++) begin
      sel.alt_out[9+i] = gen_cfg[GC_REQ_A+i];
    end
    sel.alt_out[12] = ext_intc;
    sel.alt_out[13] = ext_intc;
    sel.alt_out[14] = ext_intc;
    sel.alt_out[29] = ext_intc;
    sel.alt_out[15] = gen_cfg[GC_SUSPEND];
    sel.alt_out[16] = gen_cfg[GC_SUSPEND];
    sel.alt_out[19] = gen_cfg[GC_CACHE_SLEEP];
    sel.alt_out[20] = gen_cfg[GC_SUSPEND_STATUS_ONE_N];
    sel.alt_out[21] = gen_cfg[GC_SUSPEND_STATUS_TWO_N];
    sel.alt_out[17] = gen_cfg[GC_CPU_STOP];
    sel.alt_out[18] = gen_cfg[GC_BUS_STOP];
    sel.alt_out[22] = gen_cfg[GC_XBUS_XCVR];
    sel.alt_out[23] = gen_cfg[GC_XBUS_XCVR];
    sel.alt_out[24] = gen_cfg[GC_CLK_SELECT];
    sel.alt_out[25] = gen_cfg[GC_CLK_ALE];
    sel.alt_out[26] = gen_cfg[GC_KBD_SELECT];
  end

endmodule

// ===== gpm_pin_mux.sv
// Operation
// - Input 0 general only in extended mode
// - Input 1 always general, active low
// - Inputs 2-4 freed per request enable
// - Input 5 lost to external controller
// - Input 6 lost to clock or controller
// - Input 7 lost to serial interrupts
// - Input 8 lost to thermal detect
// - Inputs 9,10 lost to battery, lid
// - Inputs 11,12 lost to alert, ring
// - Inputs 13-21 always general
// - Outputs 0,8,27,28,30 always general
// - Output 8 low when core unpowered
// - Outputs 1-7 general only in extended mode
// - Outputs 9-11 freed per grant enable
// - Outputs 12-14,29 to external controller
// - Output 29 carries level active-low interrupt
// - Outputs 15,16,19-21 suspend and sleep
// - Outputs 17,18 clock stop controls
// - Outputs 22,23 transceiver controls
// - Outputs 24,25 clock chip decode
// - Output 26 keyboard chip select
// - Input levels readable at offset 30h
// - Output levels from offset 34h register
// - Reset values per pin default
module gpm_pin_mux
  import gpm_pkg::*;
(
  input  wire logic             CLK_SYS,
  input  wire logic             SRST,
  input  wire logic             CFG_WRITE,
  input  wire logic [31:0]      CFG_GEN_DATA,
  input  wire logic [15:0]      CFG_XBUS_DATA,
  input  wire logic             OUT_WRITE,
  input  wire logic [GPO_W-1:0] OUT_WRITE_DATA,
  input  wire logic             CORE_POWER_OK,
  input  wire logic [GPI_W-1:0] PIN_IN,
  input  wire logic [GPO_W-1:0] ALT_OUT,
  output logic      [GPI_W-1:0] PIN_LEVEL_REG,
  output logic      [GPI_W-1:0] ALT_IN,
  output logic                  GPI1_ASSERTED,
  output logic      [GPO_W-1:0] PIN_OUT,
  output logic      [GPO_W-1:0] OUT_LEVEL_REG,
  output logic      [31:0]      GEN_CONFIG,
  output logic      [15:0]      XBUS_CONFIG
);

  gpm_sel_if sel ();

  logic [31:0]      general_config_reg;
  logic [15:0]      xbus_chipsel_reg;
  logic [GPO_W-1:0] general_output;
  logic [GPI_W-1:0] pin_level_reg;
  logic [GPO_W-1:0] next_pin_out;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Defaults leave the power and decode functions on their pins, so
  // the board sees its control lines owned from the first cycle.
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      general_config_reg <= GEN_CONFIG_RST;
      xbus_chipsel_reg   <= XBUS_CFG_RST;
    end else if (CFG_WRITE) begin
      general_config_reg <= CFG_GEN_DATA;
      xbus_chipsel_reg   <= CFG_XBUS_DATA;
    end
  end

  gpm_select u_select (
    .gen_cfg  (general_config_reg),
    .xbus_cfg (xbus_chipsel_reg),
    .sel      (sel.ctrl)
  );

  // ----------------------------------------------------------------
  // Output level register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      general_output <= GPO_RST;
    end else if (OUT_WRITE) begin
      general_output <= OUT_WRITE_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Input level capture
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pin_level_reg <= '0;
    end else begin
      for (int i = 0; i < GPI_W; i++) begin
        pin_level_reg[i] <= sel.alt_in[i] ? 1'b0 : PIN_IN[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin output selection
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < GPO_W; i++) begin
      next_pin_out[i] = sel.alt_out[i] ? ALT_OUT[i] : general_output[i];
    end
    next_pin_out[0]  = general_output[0];
    next_pin_out[27] = general_output[27];
    next_pin_out[28] = general_output[28];
    next_pin_out[30] = general_output[30];
    next_pin_out[8]  = CORE_POWER_OK & general_output[8];
  end

  // The pin data is registered so alternate functions see one cycle of
  // latency; those board signals are all slow control lines.
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PIN_OUT <= GPO_RST;
    end else begin
      PIN_OUT <= next_pin_out;
    end
  end

  // ----------------------------------------------------------------
  // Alternate input routing and status
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < GPI_W; i++) begin
      ALT_IN[i] = sel.alt_in[i] & PIN_IN[i];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      GPI1_ASSERTED <= 1'b0;
    end else begin
      GPI1_ASSERTED <= ~PIN_IN[1];
    end
  end

  assign PIN_LEVEL_REG = pin_level_reg;
  assign OUT_LEVEL_REG = general_output;
  assign GEN_CONFIG    = general_config_reg;
  assign XBUS_CONFIG   = xbus_chipsel_reg;

endmodule

// ===== gpm_tb_pkg.sv
package gpm_tb_pkg;
  import gpm_pkg::*;

  function automatic logic [GPI_W-1:0] gpm_in_own(logic [31:0] g, logic [15:0] x);
    logic [GPI_W-1:0] m;
    m       = '0;
    m[0]    = ~g[0];
    m[4:2]  = g[10:8];
    m[5]    = x[8];
    m[6]    = g[14] | x[8];
    m[7]    = g[16];
    m[8]    = g[23];
    m[10:9] = g[25:24];
    m[11]   = g[15];
    m[12]   = g[27];
    return m;
  endfunction

  function automatic logic [GPO_W-1:0] gpm_exp_out(logic [31:0] g, logic [15:0] x, logic [GPO_W-1:0] alt,
                                                   logic [GPO_W-1:0] out, logic pwr);
    logic [GPO_W-1:0] m;
    logic [GPO_W-1:0] r;
    m         = '0;
    m[7:1]    = {7{~g[0]}};
    m[11:9]   = g[10:8];
    m[14:12]  = {3{x[8]}};
    m[29]     = x[8];
    m[16:15]  = {2{g[17]}};
    m[21:17]  = g[22:18];
    m[23:22]  = {2{g[28]}};
    m[26:24]  = g[31:29];
    r         = (alt & m) | (out & ~m);
    r[8]      = r[8] & pwr;
    return r;
  endfunction
endpackage

// ===== gpm_board.sv
module gpm_board (
  input  wire logic [7:0]  pat,
  output logic      [21:0] pin_in,
  output logic      [30:0] alt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Peripherals drive steady levels; the bench steps the pattern between checks.
  assign pin_in  = {pat[5:0], pat, pat};
  assign alt_out = ~{pat[6:0], pat, pat, pat};
endmodule

// ===== gpm_pin_mux_asserts.sv
module gpm_pin_mux_chk
  import gpm_pkg::*;
  import gpm_tb_pkg::*;
(
  input wire logic             CLK_SYS,
  input wire logic             SRST,
  input wire logic             CFG_WRITE,
  input wire logic [31:0]      CFG_GEN_DATA,
  input wire logic [15:0]      CFG_XBUS_DATA,
  input wire logic             OUT_WRITE,
  input wire logic [GPO_W-1:0] OUT_WRITE_DATA,
  input wire logic             CORE_POWER_OK,
  input wire logic [GPI_W-1:0] PIN_IN,
  input wire logic [GPO_W-1:0] ALT_OUT,
  input wire logic [GPI_W-1:0] PIN_LEVEL_REG,
  input wire logic [GPI_W-1:0] ALT_IN,
  input wire logic             GPI1_ASSERTED,
  input wire logic [GPO_W-1:0] PIN_OUT,
  input wire logic [GPO_W-1:0] OUT_LEVEL_REG,
  input wire logic [31:0]      GEN_CONFIG,
  input wire logic [15:0]      XBUS_CONFIG
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  property p_out_mux; !$past(SRST) |-> PIN_OUT == gpm_exp_out($past(GEN_CONFIG), $past(XBUS_CONFIG),
    $past(ALT_OUT), $past(OUT_LEVEL_REG), $past(CORE_POWER_OK)); endproperty
  property p_reset; disable iff (1'b0) SRST |=> GEN_CONFIG == GEN_CONFIG_RST && XBUS_CONFIG == XBUS_CFG_RST
    && OUT_LEVEL_REG == GPO_RST && PIN_LEVEL_REG == '0; endproperty
  property p_cfg_write; CFG_WRITE |=> GEN_CONFIG == $past(CFG_GEN_DATA) && XBUS_CONFIG == $past(CFG_XBUS_DATA); endproperty
  property p_cfg_hold; !CFG_WRITE |=> $stable(GEN_CONFIG) && $stable(XBUS_CONFIG); endproperty
  property p_out_write; OUT_WRITE |=> OUT_LEVEL_REG == $past(OUT_WRITE_DATA); endproperty
  property p_out_hold; !OUT_WRITE |=> $stable(OUT_LEVEL_REG); endproperty
  property p_level; !$past(SRST) |-> PIN_LEVEL_REG ==
    ($past(PIN_IN) & ~gpm_in_own($past(GEN_CONFIG), $past(XBUS_CONFIG))); endproperty
  property p_gpi1; !$past(SRST) |-> GPI1_ASSERTED == !$past(PIN_IN[1]); endproperty
  property p_alt_in; ALT_IN == (PIN_IN & gpm_in_own(GEN_CONFIG, XBUS_CONFIG)); endproperty

  a_out_mux: assert property (p_out_mux) else $error("pin drive wrong");
  a_reset: assert property (p_reset) else $error("reset value wrong");
  a_cfg_write: assert property (p_cfg_write) else $error("config load wrong");
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
  a_out_write: assert property (p_out_write) else $error("output reg load wrong");
  a_out_hold: assert property (p_out_hold) else $error("output reg changed");
  a_level: assert property (p_level) else $error("input level wrong");
  a_gpi1: assert property (p_gpi1) else $error("input one flag wrong");
  a_alt_in: assert property (p_alt_in) else $error("alternate input routing wrong");
  c_cfg: cover property (CFG_WRITE);
  c_pwr: cover property (!CORE_POWER_OK);
  c_out: cover property (OUT_WRITE);
endmodule

bind gpm_pin_mux gpm_pin_mux_chk i_chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .CFG_WRITE(CFG_WRITE),
  .CFG_GEN_DATA(CFG_GEN_DATA), .CFG_XBUS_DATA(CFG_XBUS_DATA), .OUT_WRITE(OUT_WRITE),
  .OUT_WRITE_DATA(OUT_WRITE_DATA), .CORE_POWER_OK(CORE_POWER_OK), .PIN_IN(PIN_IN), .ALT_OUT(ALT_OUT),
  .PIN_LEVEL_REG(PIN_LEVEL_REG), .ALT_IN(ALT_IN), .GPI1_ASSERTED(GPI1_ASSERTED), .PIN_OUT(PIN_OUT),
  .OUT_LEVEL_REG(OUT_LEVEL_REG), .GEN_CONFIG(GEN_CONFIG), .XBUS_CONFIG(XBUS_CONFIG));

// ===== test_general_purpose_pin_mux.sv
module test_general_purpose_pin_mux;
  import gpm_pkg::*;
  import gpm_tb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, cfg_wr, out_wr, pwr, gpi1;
  logic [31:0] gen_d, gen_q, g;
  logic [15:0] xb_d, xb_q, x;
  logic [30:0] out_d, out_q, pin_out, alt;
  logic [21:0] pin_in, lvl;
  logic [7:0]  pat;
  int          n_fail, samples_checked;

  gpm_board i_board (.pat(pat), .pin_in(pin_in), .alt_out(alt));
  gpm_pin_mux i_dut (.CLK_SYS(clk), .SRST(srst), .CFG_WRITE(cfg_wr), .CFG_GEN_DATA(gen_d), .CFG_XBUS_DATA(xb_d),
    .OUT_WRITE(out_wr), .OUT_WRITE_DATA(out_d), .CORE_POWER_OK(pwr), .PIN_IN(pin_in), .ALT_OUT(alt),
    .PIN_LEVEL_REG(lvl), .ALT_IN(), .GPI1_ASSERTED(gpi1), .PIN_OUT(pin_out), .OUT_LEVEL_REG(out_q),
    .GEN_CONFIG(gen_q), .XBUS_CONFIG(xb_q));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg(input logic [31:0] gv, input logic [15:0] xv);
    @(posedge clk) #1;
    cfg_wr = 1;
    gen_d = gv;
    xb_d = xv;
    @(posedge clk) #1;
    cfg_wr = 0;
  endtask

  task automatic wout(input logic [30:0] d);
    @(posedge clk) #1;
    out_wr = 1;
    out_d = d;
    @(posedge clk) #1;
    out_wr = 0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {cfg_wr, out_wr, gen_d, xb_d, out_d} = '0;
    srst = 1;
    pwr = 1;
    pat = 8'hA5;
    repeat (20) @(posedge clk);
    #1 srst = 0;
    settle();
    chk(gen_q, GEN_CONFIG_RST);
    chk(32'(xb_q), 32'(XBUS_CFG_RST));
    chk(32'(out_q), 32'(GPO_RST));
    chk(32'(pin_out), 32'(gpm_exp_out(GEN_CONFIG_RST, 16'h0000, alt, GPO_RST, 1'b1)));
    // Walk every selection bit alone, then the X-bus one, so each selectable pin group switches owner.
    for (int i = 0; i < 33; i++) begin
      g = (i < 32) ? 32'h1 << i : 32'h0;
      x = (i < 32) ? 16'h0000 : 16'h0100;
      cfg(g, x);
      wout(31'h2AAAAAAA ^ 31'(i));
      pat = 8'(i) * 8'h1D;
      settle();
      chk(32'(pin_out), 32'(gpm_exp_out(g, x, alt, 31'h2AAAAAAA ^ 31'(i), 1'b1)));
      chk(32'(lvl), 32'(pin_in & ~gpm_in_own(g, x)));
      chk({31'h0, gpi1}, {31'h0, ~pin_in[1]});
    end
    cfg(32'h0000_0001, 16'h0000);
    wout(31'h7FFFFFFF);
    pwr = 0;
    settle();
    chk(32'(pin_out), 32'h7FFFFEFF);
    pwr = 1;
    settle();
    chk(32'(pin_out), 32'h7FFFFFFF);
    end_of_test();
  end
endmodule
